// ### rtl/qri_query_rom.sv
// qri_query_rom: read-only query table for partition region 1, erase block type 2,
// plus the link field of the two-die part, with decoded field views.
// assumes straps are static pins and the register port master is on clk.
//
// Operation
// - six-byte region descriptor at P+42h
// - bits 7:0 give size exponent
// - bit 15 legacy flag voids exponent
// - valid size 23:16, invalid size 39:32
// - bit 47 legacy flag voids sizes
// - reserved descriptor bits not interpreted
// - link bits 9:0 segment address offset
// - link bits 27:10 segment index
// - link bits 30:28 type, 31 chained
// - quantity byte holds n, quantity n+1
// - quantity bits 4,5 locations; 7:6 reserved
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module qri_query_rom
  import qri_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [QRI_ADDR_W-1:0] busAddr,
  input  wire logic [QRI_DATA_W-1:0] busWdata,
  input  wire logic                  busWr,
  input  wire logic                  busRd,
  output logic      [QRI_DATA_W-1:0] busRdata,
  input  wire logic [1:0]            densitySel,
  input  wire logic [1:0]            arrangeSel,
  input  wire logic                  dieUpper,
  output qri_desc_t                  descInfo,
  output qri_link_t                  linkInfo,
  output logic                       variantReady,
  output logic                       variantBad
);

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------

  // maps straps to a table column; bit 3 flags an unsupported combination
  function automatic logic [3:0] variantCol(
    input logic [1:0] den,
    input logic [1:0] arr,
    input logic       upper
  );
    logic [3:0] res;
    res = 4'h8;
    case (den)
      QRI_DEN_512M, QRI_DEN_1G: begin
        if (arr != 2'h3) begin
          res = {1'b0, (den == QRI_DEN_1G) ? 3'h3 : 3'h0} + {2'h0, arr};
        end
      end
      QRI_DEN_2G: begin
        if (arr == QRI_ARR_SYM) begin
          res = upper ? 4'h6 : 4'h7;
        end
      end
      default: begin
        res = 4'h8;
      end
    endcase
    return res;
  endfunction

  // one table byte for a column and window index
  function automatic logic [7:0] tableByte(
    input logic [2:0] col,
    input logic [3:0] idx
  );
    logic [63:0] row;
    int unsigned sh;
    row = QRI_TABLE[idx];
    sh  = (QRI_COLS - 1 - int'(col)) * QRI_BYTE_W;
    return row[sh +: QRI_BYTE_W];
  endfunction

  // true when an address falls inside the query window
  function automatic logic inWindow(input logic [QRI_ADDR_W-1:0] a);
    return (a >= QRI_TBL_FIRST) && (a <= QRI_TBL_LAST);
  endfunction

  // ------------------------------------------------------------------
  // strap synchronisers
  // ------------------------------------------------------------------
  logic [4:0] strapRaw;
  logic [4:0] strapSync;

  assign strapRaw = {densitySel, arrangeSel, dieUpper};

  qri_sync #(
    .WIDTH (5)
  ) u_strapSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   (strapRaw),
    .pinSync (strapSync)
  );

  // ------------------------------------------------------------------
  // variant capture: wait for the synchronisers to settle, then latch once
  // straps are sampled only after reset release, so changes later are ignored
  // ------------------------------------------------------------------
  qri_state_t state_r;
  qri_state_t state_nxt;
  logic [2:0] settle_r;
  logic [2:0] settle_nxt;
  logic [2:0] col_r;
  logic [2:0] col_nxt;
  logic       bad_r;
  logic       bad_nxt;
  logic       den2g_r;
  logic       den2g_nxt;
  logic [3:0] colLookup;

  assign colLookup = variantCol(strapSync[4:3], strapSync[2:1], strapSync[0]);

  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    col_nxt    = col_r;
    bad_nxt    = bad_r;
    den2g_nxt  = den2g_r;
    case (state_r)
      QRI_ST_SYNC: begin
        if (settle_r == QRI_SETTLE_CYC) begin
          state_nxt = QRI_ST_CAPTURE;
        end else begin
          settle_nxt = settle_r + 3'h1;
        end
      end
      QRI_ST_CAPTURE: begin
        col_nxt   = colLookup[2:0];
        bad_nxt   = colLookup[3];
        den2g_nxt = (strapSync[4:3] == QRI_DEN_2G);
        state_nxt = QRI_ST_READY;
      end
      QRI_ST_READY: begin
        state_nxt = QRI_ST_READY;
      end
      default: begin
        state_nxt = QRI_ST_SYNC;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= QRI_ST_SYNC;
      settle_r <= 3'h0;
      col_r    <= 3'h0;
      bad_r    <= 1'b0;
      den2g_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      col_r    <= col_nxt;
      bad_r    <= bad_nxt;
      den2g_r  <= den2g_nxt;
    end
  end

  logic ready;
  logic tableOk;

  assign ready   = (state_r == QRI_ST_READY);
  assign tableOk = ready && !bad_r;

  // ------------------------------------------------------------------
  // descriptor and link assembly from the fixed table
  // ------------------------------------------------------------------
  logic [47:0] descRaw;
  logic [31:0] linkRaw;
  logic [7:0]  qtyRaw;
  logic [3:0]  descBase;

  // descriptor starts at P+42h, expressed as a window index
  assign descBase = 4'((QRI_P_BASE + QRI_DESC_OFS) - QRI_TBL_FIRST);

  always_comb begin
    descRaw = '0;
    linkRaw = '0;
    for (int i = 0; i < QRI_DESC_LEN; i++) begin
      descRaw[i*QRI_BYTE_W +: QRI_BYTE_W] = tableByte(col_r, descBase + 4'(i));
    end
    for (int j = 0; j < QRI_LINK_LEN; j++) begin
      linkRaw[j*QRI_BYTE_W +: QRI_BYTE_W] = tableByte(col_r, QRI_LINK_IDX + 4'(j));
    end
    qtyRaw = tableByte(col_r, QRI_QTY_IDX);
  end

  qri_desc_t descDec;
  qri_link_t linkDec;

  qri_field_decode u_fieldDecode (
    .descRaw   (descRaw),
    .linkRaw   (linkRaw),
    .qtyRaw    (qtyRaw),
    .linkValid (den2g_r),
    .descOut   (descDec),
    .linkOut   (linkDec)
  );

  qri_desc_t descInfo_r;
  qri_desc_t descInfo_nxt;
  qri_link_t linkInfo_r;
  qri_link_t linkInfo_nxt;

  // decoded views stay zero until a valid variant is latched
  always_comb begin
    descInfo_nxt = '0;
    linkInfo_nxt = '0;
    if (tableOk) begin
      descInfo_nxt = descDec;
      linkInfo_nxt = linkDec;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      descInfo_r <= '0;
      linkInfo_r <= '0;
    end else begin
      descInfo_r <= descInfo_nxt;
      linkInfo_r <= linkInfo_nxt;
    end
  end

  // ------------------------------------------------------------------
  // control register: query enable and a sticky table-write flag
  // ------------------------------------------------------------------
  logic qen_r;
  logic qen_nxt;
  logic wrSeen_r;
  logic wrSeen_nxt;
  logic ctrlWr;
  logic tblWr;

  assign ctrlWr = busWr && (busAddr == QRI_REG_CTRL);
  assign tblWr  = busWr && inWindow(busAddr);

  always_comb begin
    qen_nxt    = qen_r;
    wrSeen_nxt = wrSeen_r;
    if (ctrlWr) begin
      qen_nxt = busWdata[QRI_CTRL_QEN];
      if (busWdata[QRI_CTRL_WCLR]) begin
        wrSeen_nxt = 1'b0;
      end
    end
    // a write to the table is dropped; only the flag records it
    if (tblWr) begin
      wrSeen_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qen_r    <= QRI_QEN_RST;
      wrSeen_r <= 1'b0;
    end else begin
      qen_r    <= qen_nxt;
      wrSeen_r <= wrSeen_nxt;
    end
  end

  // ------------------------------------------------------------------
  // read path: data one cycle after the strobe, only in that cycle
  // ------------------------------------------------------------------
  logic [QRI_DATA_W-1:0] rdata_r;
  logic [QRI_DATA_W-1:0] rdata_nxt;
  logic [3:0]            rdIdx;

  assign rdIdx = 4'(busAddr - QRI_TBL_FIRST);

  always_comb begin
    rdata_nxt = '0;
    if (busRd) begin
      if (busAddr == QRI_REG_CTRL) begin
        rdata_nxt = {14'h0000, wrSeen_r, qen_r};
      end else if (busAddr == QRI_REG_STATUS) begin
        rdata_nxt = {9'h000, den2g_r, bad_r, ready, col_r, 1'b0};
      end else if (inWindow(busAddr) && qen_r && tableOk) begin
        rdata_nxt = {8'h00, tableByte(col_r, rdIdx)};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign busRdata     = rdata_r;
  assign descInfo     = descInfo_r;
  assign linkInfo     = linkInfo_r;
  assign variantReady = ready;
  assign variantBad   = bad_r;

endmodule

// ### rtl/qri_pkg.sv
// qri_pkg: constants, table contents and carrier types for the query region info rom.
// assumes one 20 MHz clock; table word offsets are query offsets on the 16-bit bus.
package qri_pkg;

  localparam int unsigned QRI_CLK_HZ      = 20_000_000;
  localparam int unsigned QRI_ADDR_W      = 10;
  localparam int unsigned QRI_DATA_W      = 16;
  localparam int unsigned QRI_BYTE_W      = 8;
  localparam int unsigned QRI_COLS        = 8;
  localparam int unsigned QRI_TBL_LEN     = 14;

  // query offsets: base P, descriptor at P+42h, table window 144h..151h
  localparam logic [9:0] QRI_P_BASE       = 10'h10A;
  localparam logic [9:0] QRI_DESC_OFS     = 10'h042;
  localparam logic [9:0] QRI_TBL_FIRST    = 10'h144;
  localparam logic [9:0] QRI_TBL_LAST     = 10'h151;

  // register offsets of the block's own control and status words
  localparam logic [9:0] QRI_REG_CTRL     = 10'h000;
  localparam logic [9:0] QRI_REG_STATUS   = 10'h001;
  localparam int unsigned QRI_CTRL_QEN    = 0;
  localparam int unsigned QRI_CTRL_WCLR   = 1;
  localparam logic        QRI_QEN_RST     = 1'b0;

  // byte positions inside the window (index 0 = 144h)
  localparam logic [3:0] QRI_LINK_IDX     = 4'h0;
  localparam logic [3:0] QRI_QTY_IDX      = 4'h4;
  localparam int unsigned QRI_LINK_LEN    = 4;
  localparam int unsigned QRI_DESC_LEN    = 6;

  // descriptor field positions
  localparam int unsigned QRI_D_EXP_LSB   = 0;
  localparam int unsigned QRI_D_LEG0_BIT  = 15;
  localparam int unsigned QRI_D_VAL_LSB   = 16;
  localparam int unsigned QRI_D_INV_LSB   = 32;
  localparam int unsigned QRI_D_LEG1_BIT  = 47;

  // link field positions
  localparam int unsigned QRI_L_OFS_LSB   = 0;
  localparam int unsigned QRI_L_OFS_W     = 10;
  localparam int unsigned QRI_L_SEG_LSB   = 10;
  localparam int unsigned QRI_L_SEG_W     = 18;
  localparam int unsigned QRI_L_TYPE_LSB  = 28;
  localparam int unsigned QRI_L_TYPE_W    = 3;
  localparam int unsigned QRI_L_NEXT_BIT  = 31;
  localparam int unsigned QRI_Q_N_W       = 4;
  localparam int unsigned QRI_Q_TDIE_BIT  = 4;
  localparam int unsigned QRI_Q_LTAB_BIT  = 5;

  // strap selections
  localparam logic [1:0] QRI_DEN_512M     = 2'h0;
  localparam logic [1:0] QRI_DEN_1G       = 2'h1;
  localparam logic [1:0] QRI_DEN_2G       = 2'h2;
  localparam logic [1:0] QRI_ARR_TOP      = 2'h0;
  localparam logic [1:0] QRI_ARR_BOT      = 2'h1;
  localparam logic [1:0] QRI_ARR_SYM      = 2'h2;
  localparam logic [2:0] QRI_SETTLE_CYC   = 3'h3;

  // one row per query offset, columns from msb: 512M top/bot/sym, 1G top/bot/sym, 2G upper/lower
  localparam logic [0:13][63:0] QRI_TABLE = '{
    64'h03FEFF03FEFFFF10, 64'h0001FF0003FFFFC8, 64'h8000FF8000FFFF00, 64'h0002FF0002FFFF00,
    64'h6464FF6464FFFF10, 64'h0000FF0000FFFFFF, 64'h0202FF0202FFFFFF, 64'h0303FF0303FFFFFF,
    64'h0000FF0000FFFFFF, 64'h8080FF8080FFFFFF, 64'h0000FF0000FFFFFF, 64'h0000FF0000FFFFFF,
    64'h0000FF0000FFFFFF, 64'h8080FF8080FFFFFF};

  typedef enum logic [1:0] {
    QRI_ST_SYNC    = 2'h0,
    QRI_ST_CAPTURE = 2'h1,
    QRI_ST_READY   = 2'h3
  } qri_state_t;

  typedef struct packed {
    logic [7:0] progExp;
    logic       progLegacy;
    logic [7:0] validSize;
    logic [7:0] invalidSize;
    logic       ctrlLegacy;
  } qri_desc_t;

  typedef struct packed {
    logic        present;
    logic [9:0]  segOffset;
    logic [17:0] segIndex;
    logic [2:0]  memType;
    logic        chained;
    logic [4:0]  quantity;
    logic        tableDieLoc;
    logic        linkTableLoc;
  } qri_link_t;

endpackage

// ### rtl/qri_sync.sv
// qri_sync: two-flop synchroniser for a group of strap pins.
// assumes each bit is a slow level; bits are not guaranteed coherent with each other.
`timescale 1ns/1ps
module qri_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pinIn[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign pinSync = sync_r;

endmodule

// ### rtl/qri_field_decode.sv
// qri_field_decode: splits raw descriptor, link and quantity bytes into named fields.
// assumes raw bytes come straight from the table; purely combinational.
`timescale 1ns/1ps
module qri_field_decode
  import qri_pkg::*;
(
  input  wire logic [47:0] descRaw,
  input  wire logic [31:0] linkRaw,
  input  wire logic [7:0]  qtyRaw,
  input  wire logic        linkValid,
  output qri_desc_t        descOut,
  output qri_link_t        linkOut
);

  logic [4:0] qtyPlusOne;

  // n is 4 bits, quantity n+1 needs 5
  assign qtyPlusOne = {1'b0, qtyRaw[QRI_Q_N_W-1:0]} + 5'h01;

  always_comb begin
    descOut             = '0;
    descOut.progExp     = descRaw[QRI_D_EXP_LSB +: QRI_BYTE_W];
    descOut.progLegacy  = descRaw[QRI_D_LEG0_BIT];
    descOut.validSize   = descRaw[QRI_D_VAL_LSB +: QRI_BYTE_W];
    descOut.invalidSize = descRaw[QRI_D_INV_LSB +: QRI_BYTE_W];
    descOut.ctrlLegacy  = descRaw[QRI_D_LEG1_BIT];
    // reserved bits 14:8, 31:24, 46:40 are deliberately not carried
    linkOut              = '0;
    if (linkValid) begin
      linkOut.present      = 1'b1;
      linkOut.segOffset    = linkRaw[QRI_L_OFS_LSB +: QRI_L_OFS_W];
      linkOut.segIndex     = linkRaw[QRI_L_SEG_LSB +: QRI_L_SEG_W];
      linkOut.memType      = linkRaw[QRI_L_TYPE_LSB +: QRI_L_TYPE_W];
      linkOut.chained      = linkRaw[QRI_L_NEXT_BIT];
      linkOut.quantity     = qtyPlusOne;
      linkOut.tableDieLoc  = qtyRaw[QRI_Q_TDIE_BIT];
      linkOut.linkTableLoc = qtyRaw[QRI_Q_LTAB_BIT];
    end
  end

endmodule

// ### test/qri_query_rom_monitor.sv
// qri_query_rom_monitor: port-level checks for the query table block.
// assumes only the top module ports are visible; bound at the foot of this file.
`timescale 1ns/1ps
module qri_query_rom_monitor
  import qri_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [QRI_ADDR_W-1:0] busAddr,
  input wire logic [QRI_DATA_W-1:0] busWdata,
  input wire logic                  busWr,
  input wire logic                  busRd,
  input wire logic [QRI_DATA_W-1:0] busRdata,
  input wire logic [1:0]            densitySel,
  input wire logic [1:0]            arrangeSel,
  input wire logic                  dieUpper,
  input wire qri_desc_t             descInfo,
  input wire qri_link_t             linkInfo,
  input wire logic                  variantReady,
  input wire logic                  variantBad
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // field checks only fire on a nonzero byte, since a disabled table reads zero
  a_rdata_one_cycle: assert property (!$past(busRd) |-> busRdata == 16'h0000)
    else $error("read data outside the answer cycle");
  a_upper_lanes: assert property (busRdata[15:8] == 8'h00)
    else $error("upper byte lanes not zero");
  a_exp_byte: assert property ($past(busRd && busAddr == 10'h14C) && busRdata != 16'h0000
    |-> busRdata[7:0] == descInfo.progExp) else $error("exponent field mismatch");
  a_prog_legacy: assert property ($past(busRd && busAddr == 10'h14D) && busRdata != 16'h0000
    |-> busRdata[7] == descInfo.progLegacy) else $error("region legacy flag mismatch");
  a_valid_size: assert property ($past(busRd && busAddr == 10'h14E) && busRdata != 16'h0000
    |-> busRdata[7:0] == descInfo.validSize) else $error("valid size mismatch");
  a_invalid_size: assert property ($past(busRd && busAddr == 10'h150) && busRdata != 16'h0000
    |-> busRdata[7:0] == descInfo.invalidSize) else $error("invalid size mismatch");
  a_ctrl_legacy: assert property ($past(busRd && busAddr == 10'h151) && busRdata != 16'h0000
    |-> busRdata[7] == descInfo.ctrlLegacy) else $error("control legacy flag mismatch");
  a_link_offset: assert property ($past(busRd && busAddr == 10'h144) && linkInfo.present
    && busRdata != 16'h0000 |-> busRdata[7:0] == linkInfo.segOffset[7:0]) else $error("link offset mismatch");
  a_link_type: assert property ($past(busRd && busAddr == 10'h147) && linkInfo.present
    && busRdata != 16'h0000 |-> busRdata[7:4] == {linkInfo.chained, linkInfo.memType})
    else $error("link type mismatch");
  a_link_qty: assert property ($past(busRd && busAddr == 10'h148) && linkInfo.present
    && busRdata != 16'h0000 |-> 5'(busRdata[3:0]) + 5'h01 == linkInfo.quantity
    && busRdata[5:4] == {linkInfo.linkTableLoc, linkInfo.tableDieLoc}) else $error("quantity byte mismatch");
  a_fields_gated: assert property (!variantReady || variantBad |-> descInfo == '0 && linkInfo == '0)
    else $error("decoded fields before a valid variant");
  a_straps_held: assert property (variantReady |=> variantReady && $stable(variantBad))
    else $error("variant changed after latch");

  c_table_read: cover property ($past(busRd) && busRdata != 16'h0000);
  c_link_seen: cover property (linkInfo.present);
  c_bad_variant: cover property (variantBad);
  c_link_chained: cover property (linkInfo.chained);
endmodule

bind qri_query_rom qri_query_rom_monitor mon_u (
  .clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
  .busRdata(busRdata), .densitySel(densitySel), .arrangeSel(arrangeSel), .dieUpper(dieUpper),
  .descInfo(descInfo), .linkInfo(linkInfo), .variantReady(variantReady), .variantBad(variantBad)
);

// ### test/qri_host_model.sv
// qri_host_model: host memory controller issuing single-cycle reads and writes.
// assumes callers enter just after a rising edge of clk.
`timescale 1ns/1ps
module qri_host_model
  import qri_pkg::*;
(
  input  wire logic                  clk,
  output logic      [QRI_ADDR_W-1:0] busAddr,
  output logic      [QRI_DATA_W-1:0] busWdata,
  output logic                       busWr,
  output logic                       busRd,
  input  wire logic [QRI_DATA_W-1:0] busRdata
);
  initial begin
    busAddr = '0;
    busWdata = '0;
    busWr = 1'b0;
    busRd = 1'b0;
  end

  // strobes drop at the taking edge, so calls chain with no gap
  task automatic wr(input logic [QRI_ADDR_W-1:0] a, input logic [QRI_DATA_W-1:0] d);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge clk);
    busWr <= 1'b0;
    busWdata <= ~d; // stale data is not left on the bus
    #1;
  endtask

  task automatic rd(input logic [QRI_ADDR_W-1:0] a, output logic [QRI_DATA_W-1:0] d);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRd <= 1'b0;
    #1;
    d = busRdata;
  endtask

  task automatic idle();
    @(posedge clk);
    #1;
  endtask
endmodule

// ### test/qri_query_rom_tb_top.sv
// qri_query_rom_tb_top: boots several strap variants and reads the table back.
// assumes the host model as the only bus master.
`timescale 1ns/1ps
module qri_query_rom_tb_top
  import qri_pkg::*;
;
  localparam logic [0:13][7:0] ROW_512T = 112'h0300800064000203008000000080;
  localparam logic [0:13][7:0] ROW_2GL  = 112'h10C8000010FFFFFFFFFFFFFFFFFF;

  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [QRI_ADDR_W-1:0] busAddr;
  logic [QRI_DATA_W-1:0] busWdata;
  logic                  busWr;
  logic                  busRd;
  logic [QRI_DATA_W-1:0] busRdata;
  logic [1:0]            densitySel = 2'h0;
  logic [1:0]            arrangeSel = 2'h0;
  logic                  dieUpper = 1'b0;
  qri_desc_t             descInfo;
  qri_link_t             linkInfo;
  logic                  variantReady;
  logic                  variantBad;
  int                    failures = 0;
  int                    totalChecks = 0;

  always #25 clk = ~clk;

  qri_query_rom dut_u (
    .clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
    .busRdata(busRdata), .densitySel(densitySel), .arrangeSel(arrangeSel), .dieUpper(dieUpper),
    .descInfo(descInfo), .linkInfo(linkInfo), .variantReady(variantReady), .variantBad(variantBad)
  );

  qri_host_model host_u (
    .clk(clk), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata)
  );

  task automatic results();
    if (failures == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdChk(input logic [QRI_ADDR_W-1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host_u.rd(a, d);
    chk("busRdata", 64'(exp), 64'(d));
  endtask

  task automatic boot(input logic [1:0] den, input logic [1:0] arr, input logic up);
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    densitySel <= den;
    arrangeSel <= arr;
    dieUpper <= up;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (variantReady !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("variantReady", 64'h1, 64'(variantReady));
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    boot(QRI_DEN_512M, QRI_ARR_TOP, 1'b0);
    rdChk(10'h14D, 16'h0000);
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    for (int i = 0; i < 14; i++) rdChk(QRI_TBL_FIRST + 10'(i), {8'h00, ROW_512T[i]});
    host_u.idle();
    chk("busRdata", 64'h0, 64'(busRdata));
    rdChk(10'h3FF, 16'h0000);
    chk("descInfo", 64'(qri_desc_t'{8'h00, 1'b1, 8'h00, 8'h00, 1'b1}), 64'(descInfo));
    chk("linkInfo", 64'h0, 64'(linkInfo));
    densitySel <= QRI_DEN_2G;
    host_u.wr(10'h14D, 16'h00FF);
    rdChk(10'h14D, 16'h0080);
    rdChk(QRI_REG_CTRL, 16'h0003);
    host_u.wr(QRI_REG_CTRL, 16'h0003);
    rdChk(QRI_REG_CTRL, 16'h0001);
    rdChk(QRI_REG_STATUS, 16'h0010);

    boot(QRI_DEN_2G, QRI_ARR_SYM, 1'b0);
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    for (int i = 0; i < 14; i++) rdChk(QRI_TBL_FIRST + 10'(i), {8'h00, ROW_2GL[i]});
    chk("descInfo", 64'(qri_desc_t'{8'hFF, 1'b1, 8'hFF, 8'hFF, 1'b1}), 64'(descInfo));
    chk("linkInfo", 64'(qri_link_t'{1'b1, 10'h010, 18'h00032, 3'h0, 1'b0, 5'h01, 1'b1, 1'b0}),
        64'(linkInfo));
    rdChk(QRI_REG_STATUS, 16'h005E);

    // upper die reads all ones, so every link field reads its maximum
    boot(QRI_DEN_2G, QRI_ARR_SYM, 1'b1);
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    for (int i = 0; i < 14; i++) rdChk(QRI_TBL_FIRST + 10'(i), 16'h00FF);
    chk("linkInfo", 64'(qri_link_t'{1'b1, 10'h3FF, 18'h3FFFF, 3'h7, 1'b1, 5'h10, 1'b1, 1'b1}),
        64'(linkInfo));
    rdChk(QRI_REG_STATUS, 16'h005C);

    boot(QRI_DEN_1G, QRI_ARR_BOT, 1'b0);
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    rdChk(10'h144, 16'h00FE);
    rdChk(10'h145, 16'h0003);
    rdChk(QRI_REG_STATUS, 16'h0018);

    boot(QRI_DEN_512M, QRI_ARR_SYM, 1'b0);
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    rdChk(10'h151, 16'h00FF);
    rdChk(QRI_REG_STATUS, 16'h0014);

    boot(QRI_DEN_1G, QRI_ARR_SYM, 1'b0);
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    rdChk(10'h14D, 16'h00FF);
    rdChk(QRI_REG_STATUS, 16'h001A);

    boot(2'h3, QRI_ARR_TOP, 1'b0);
    chk("variantBad", 64'h1, 64'(variantBad));
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    rdChk(10'h144, 16'h0000);
    chk("descInfo", 64'h0, 64'(descInfo));
    rdChk(QRI_REG_STATUS, 16'h0030);

    // a two-die part must be symmetric, so top arrangement is refused
    boot(QRI_DEN_2G, QRI_ARR_TOP, 1'b0);
    chk("variantBad", 64'h1, 64'(variantBad));
    host_u.wr(QRI_REG_CTRL, 16'h0001);
    rdChk(10'h148, 16'h0000);
    chk("linkInfo", 64'h0, 64'(linkInfo));
    rdChk(QRI_REG_STATUS, 16'h0070);
    results();
  end

  // the whole sequence needs about 150 cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    results();
  end
endmodule
